// file: rtl/ced_pkg.sv
/*
 * Constants shared by the error dispatch and address check block.
 * Assumes opcodes arrive as three octal digits packed into nine bits.
 */
// Operation
// - Addresses above 21 bits: undefined if inside field length, else range error.
// - Beyond installed memory: writes dropped, reads return all ones, no wrap.
// - Address in reconfigured-away region wraps around installed memory.
// - Hardware errors while running are never masked and always exchange to executive state.
// - Job-mode hardware error returns to monitor; monitor-mode one simulates halt.
// - After monitor hardware error, peripheral exchanges ignored until deadstart.
// - Monitor-mode software faults exchange to executive state instead of halting.
// - Job-mode software errors go to microcode, except opcode 017 to executive.
// - Illegal: 017; 011-013, 464-467 in parcels 1-3; 30-bit in parcel 3.
// - Block copy illegal without extended enable or with both bit-23 flags.
// - Single-word extended opcodes illegal only when extended enable is clear.
// - Extended enable is flag bit 56; clear makes extended opcodes illegal.
package ced_pkg;
    // ********************************
    // Opcodes and decode fields
    // ********************************
    localparam logic [8:0] OP_BCOPY_RD = 9'h009;
    localparam logic [8:0] OP_BCOPY_WR = 9'h00A;
    localparam logic [8:0] OP_XCHG = 9'h00B;
    localparam logic [8:0] OP_XRD = 9'h00C;
    localparam logic [8:0] OP_XWR = 9'h00D;
    localparam logic [8:0] OP_TRAP = 9'h00F;
    localparam logic [8:0] OP_CMP_LO = 9'h134;
    localparam logic [8:0] OP_CMP_HI = 9'h137;
    localparam logic [5:0] OP_ZERO_MAJOR = 6'h00;
    localparam logic [1:0] PARCEL_LAST = 2'h3;
    localparam logic [1:0] PARCEL_FIRST = 2'h0;
    // Flag register occupies bits 56..51; bit 56 is the top of the six.
    localparam int FLAG_UEM_BIT = 5;
    localparam int CM_ADDR_W = 21;
    // ********************************
    // Register map
    // ********************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_INST_MASK = 4'h1;
    localparam logic [3:0] REG_RCFG_LO = 4'h2;
    localparam logic [3:0] REG_RCFG_HI = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_IMASK = 4'h5;
    localparam logic [3:0] REG_STATE = 4'h6;
    localparam logic [20:0] INST_MASK_RST = 21'h1FFFFF;
    localparam int NUM_EV = 6;
    localparam int EV_HW = 0;
    localparam int EV_ILL = 1;
    localparam int EV_RANGE = 2;
    localparam int EV_UNDEF = 3;
    localparam int EV_NOMEM = 4;
    localparam int EV_PPREF = 5;
    // ********************************
    // Exchange causes and states
    // ********************************
    localparam logic [3:0] CAUSE_NONE = 4'h0;
    localparam logic [3:0] CAUSE_HW_JOB = 4'h1;
    localparam logic [3:0] CAUSE_HW_MON = 4'h2;
    localparam logic [3:0] CAUSE_SW_MON = 4'h3;
    localparam logic [3:0] CAUSE_TRAP = 4'h4;
    typedef enum logic [1:0] {ST_RUN, ST_EXEC, ST_LOCK} ced_state_type;
endpackage

// file: rtl/ced_illegal_dec.sv
/*
 * Combinational illegal-instruction decoder.
 * Assumes the fields are stable in the cycle the pipeline offers them.
 */
`timescale 1ns/100ps
module ced_illegal_dec (
    input wire logic [8:0] op,
    input wire logic [1:0] parcel,
    input wire logic long_instr,
    input wire logic uem_en,
    input wire logic x0_bit23,
    input wire logic fle_bit23,
    output logic illegal,
    output logic zero_op
);
    import ced_pkg::*;
    logic cmp_op;
    logic bcopy_op;
    logic parcel_bad;
    // Opcode classes; combinational so the verdict precedes commit.
    assign cmp_op = (op >= OP_CMP_LO) && (op <= OP_CMP_HI);
    assign bcopy_op = (op == OP_BCOPY_RD) || (op == OP_BCOPY_WR);
    assign zero_op = (op[8:3] == OP_ZERO_MAJOR);
    assign parcel_bad = (parcel != PARCEL_FIRST) && (bcopy_op || op == OP_XCHG || cmp_op);
    always_comb begin
        illegal = (op == OP_TRAP) || parcel_bad || (long_instr && parcel == PARCEL_LAST);
        if (bcopy_op && (!uem_en || (x0_bit23 && fle_bit23))) begin
            illegal = 1'b1;
        end
        if ((op == OP_XRD || op == OP_XWR) && !uem_en) begin
            illegal = 1'b1;
        end
    end
endmodule

// file: rtl/ced_addr_chk.sv
/*
 * Combinational central-memory address classifier.
 * Assumes installed memory is a power of two given as a size-minus-one mask.
 */
`timescale 1ns/100ps
module ced_addr_chk #(
    parameter int REL_W = 24
) (
    input wire logic [REL_W-1:0] rel_addr,
    input wire logic [ced_pkg::CM_ADDR_W-1:0] ref_addr,
    input wire logic [ced_pkg::CM_ADDR_W-1:0] field_len,
    input wire logic [ced_pkg::CM_ADDR_W-1:0] inst_mask,
    input wire logic rcfg_en,
    input wire logic [ced_pkg::CM_ADDR_W-1:0] rcfg_lo,
    input wire logic [ced_pkg::CM_ADDR_W-1:0] rcfg_hi,
    output logic range_err,
    output logic undef_op,
    output logic no_mem,
    output logic [ced_pkg::CM_ADDR_W-1:0] abs_addr
);
    import ced_pkg::*;
    logic [REL_W:0] abs_full;
    logic in_fl;
    logic too_big;
    logic [CM_ADDR_W-1:0] abs_lo;
    assign abs_full = {1'b0, rel_addr} + {{(REL_W+1-CM_ADDR_W){1'b0}}, ref_addr};
    assign abs_lo = abs_full[CM_ADDR_W-1:0];
    assign too_big = |abs_full[REL_W:CM_ADDR_W];
    assign in_fl = rel_addr < {{(REL_W-CM_ADDR_W){1'b0}}, field_len};
    // Classification, in priority order of the checks.
    always_comb begin
        range_err = 1'b0;
        undef_op = 1'b0;
        no_mem = 1'b0;
        abs_addr = abs_lo;
        if (too_big) begin
            undef_op = in_fl;
            range_err = !in_fl;
        end else if (!in_fl) begin
            range_err = 1'b1;
        end else if (rcfg_en && abs_lo >= rcfg_lo && abs_lo < rcfg_hi) begin
            abs_addr = abs_lo & inst_mask;
        end else if ((abs_lo & ~inst_mask) != '0) begin
            no_mem = 1'b1;
        end
    end
endmodule

// file: rtl/ced_top.sv
/*
 * Exception dispatch and central-memory address check for the processor.
 * Assumes the pipeline offers one request per cycle and
 * holds its update until commit_ok is seen in that cycle.
 */
`timescale 1ns/100ps
module ced_top #(
    parameter int REL_W = 24
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic inst_valid,
    input wire logic [8:0] inst_op,
    input wire logic [1:0] inst_parcel,
    input wire logic inst_long,
    input wire logic monitor_mode,
    input wire logic index_register_zero_b23,
    input wire logic extended_field_length_b23,
    input wire logic [5:0] xpkg_flags,
    input wire logic exit_mode_range,
    input wire logic exit_mode_arith,
    input wire logic arith_fault,
    output logic commit_ok,
    input wire logic mem_req,
    input wire logic mem_wr,
    input wire logic mem_fetch,
    input wire logic [REL_W-1:0] mem_rel_addr,
    input wire logic [ced_pkg::CM_ADDR_W-1:0] ref_addr_central,
    input wire logic [ced_pkg::CM_ADDR_W-1:0] central_field_length,
    output logic mem_go_q,
    output logic mem_wr_q,
    output logic mem_read_ones_q,
    output logic [ced_pkg::CM_ADDR_W-1:0] mem_abs_q,
    input wire logic hw_err,
    input wire logic exec_done,
    input wire logic deadstart,
    input wire logic pp_exch_req,
    output logic pp_exch_grant,
    output logic exec_exchange_q,
    output logic [3:0] exec_cause_q,
    output logic micro_trap_q,
    output logic return_monitor_q,
    output logic sim_halt_q
);
    import ced_pkg::*;

    // ********************************
    // Declarations
    // ********************************
    ced_state_type state_q;
    logic rcfg_en_q;
    logic [CM_ADDR_W-1:0] inst_mask_q;
    logic [CM_ADDR_W-1:0] rcfg_lo_q;
    logic [CM_ADDR_W-1:0] rcfg_hi_q;
    logic [NUM_EV-1:0] status_q;
    logic [NUM_EV-1:0] imask_q;
    logic [NUM_EV-1:0] ev_set;
    logic [NUM_EV-1:0] ev_clr;
    logic illegal;
    logic zero_op;
    logic range_err;
    logic undef_op;
    logic no_mem;
    logic [CM_ADDR_W-1:0] abs_addr;
    logic mem_range;
    logic sw_fault;
    logic mon_sw_exch;
    logic job_sw_fault;
    logic trap_exch;
    logic running;

    // ********************************
    // Checkers
    // ********************************
    // Decode runs on the offered instruction with no register stage.
    ced_illegal_dec u_dec (
        .op(inst_op),
        .parcel(inst_parcel),
        .long_instr(inst_long),
        .uem_en(xpkg_flags[FLAG_UEM_BIT]),
        .x0_bit23(index_register_zero_b23),
        .fle_bit23(extended_field_length_b23),
        .illegal(illegal),
        .zero_op(zero_op)
    );

    // Address class is likewise combinational so a fault is known pre-commit.
    ced_addr_chk #(
        .REL_W(REL_W)
    ) u_addr (
        .rel_addr(mem_rel_addr),
        .ref_addr(ref_addr_central),
        .field_len(central_field_length),
        .inst_mask(inst_mask_q),
        .rcfg_en(rcfg_en_q),
        .rcfg_lo(rcfg_lo_q),
        .rcfg_hi(rcfg_hi_q),
        .range_err(range_err),
        .undef_op(undef_op),
        .no_mem(no_mem),
        .abs_addr(abs_addr)
    );

    // ********************************
    // Fault classification
    // ********************************
    assign running = (state_q == ST_RUN);
    assign mem_range = mem_req && range_err;
    assign sw_fault = (inst_valid && (illegal || zero_op))
        || (mem_range && (mem_fetch || exit_mode_range))
        || (mem_req && undef_op)
        || (arith_fault && exit_mode_arith);
    assign mon_sw_exch = running && monitor_mode && sw_fault;
    // job-mode trap opcode goes to executive state
    assign trap_exch = running && !monitor_mode && inst_valid && inst_op == OP_TRAP;
    assign job_sw_fault = running && !monitor_mode && sw_fault && !trap_exch;
    // commit gate
    // An illegal instruction or a range or undefined access never commits, so the exchange sees
    // the prior state; the cost is a combinational path.
    assign commit_ok = running && !hw_err && !(inst_valid && illegal)
        && !(mem_req && (range_err || undef_op));

    // ********************************
    // Dispatch state
    // ********************************
    // Hardware errors outrank same-cycle software faults.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_RUN;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (hw_err) begin
                        state_q <= monitor_mode ? ST_LOCK : ST_EXEC;
                    end else if (mon_sw_exch || trap_exch) begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (exec_done) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_LOCK: begin
                    // only a deadstart leaves this state
                    if (deadstart) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // Exchange pulse, its cause and the microcode trap pulse.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            exec_exchange_q <= 1'b0;
            exec_cause_q <= CAUSE_NONE;
            micro_trap_q <= 1'b0;
        end else begin
            exec_exchange_q <= running && (hw_err || mon_sw_exch || trap_exch);
            micro_trap_q <= job_sw_fault && !hw_err;
            if (running && hw_err) begin
                exec_cause_q <= monitor_mode ? CAUSE_HW_MON : CAUSE_HW_JOB;
            end else if (mon_sw_exch) begin
                exec_cause_q <= CAUSE_SW_MON;
            end else if (trap_exch) begin
                exec_cause_q <= CAUSE_TRAP;
            end
        end
    end

    // follow-up after hardware error
    // Return to monitor pulses at executive completion; the halt level
    // stays up while the lock holds.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            return_monitor_q <= 1'b0;
            sim_halt_q <= 1'b0;
        end else begin
            return_monitor_q <= (state_q == ST_EXEC) && exec_done
                && exec_cause_q == CAUSE_HW_JOB;
            sim_halt_q <= (state_q == ST_LOCK) && !deadstart;
        end
    end

    assign pp_exch_grant = pp_exch_req && (state_q != ST_LOCK);

    // ********************************
    // Memory request outcome
    // ********************************
    // drop writes, read all ones
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_go_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_read_ones_q <= 1'b0;
            mem_abs_q <= '0;
        end else begin
            mem_go_q <= mem_req && !range_err && !undef_op && !no_mem && running;
            mem_wr_q <= mem_req && mem_wr && !range_err && !undef_op && !no_mem;
            mem_read_ones_q <= mem_req && !mem_wr && no_mem;
            mem_abs_q <= abs_addr;
        end
    end

    // ********************************
    // Register file
    // ********************************
    // Software-written controls steer the address checker and the interrupt mask.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rcfg_en_q <= 1'b0;
            inst_mask_q <= INST_MASK_RST;
            rcfg_lo_q <= '0;
            rcfg_hi_q <= '0;
            imask_q <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: rcfg_en_q <= reg_wdata[0];
                REG_INST_MASK: inst_mask_q <= reg_wdata[CM_ADDR_W-1:0];
                REG_RCFG_LO: rcfg_lo_q <= reg_wdata[CM_ADDR_W-1:0];
                REG_RCFG_HI: rcfg_hi_q <= reg_wdata[CM_ADDR_W-1:0];
                REG_IMASK: imask_q <= reg_wdata[NUM_EV-1:0];
                default: begin
                end
            endcase
        end
    end

    // Event sources for the sticky status bits.
    assign ev_set[EV_HW] = hw_err;
    assign ev_set[EV_ILL] = inst_valid && illegal;
    assign ev_set[EV_RANGE] = mem_range;
    assign ev_set[EV_UNDEF] = mem_req && undef_op;
    assign ev_set[EV_NOMEM] = mem_req && no_mem;
    assign ev_set[EV_PPREF] = pp_exch_req && (state_q == ST_LOCK);
    assign ev_clr = (reg_wr && reg_addr == REG_STATUS) ? reg_wdata[NUM_EV-1:0] : '0;

    // Write-one-to-clear status; a new event in the clearing cycle wins.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EV; gi++) begin : g_stat
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    status_q[gi] <= 1'b0;
                end else begin
                    status_q[gi] <= ev_set[gi] | (status_q[gi] & ~ev_clr[gi]);
                end
            end
        end
    endgenerate

    assign irq = |(status_q & imask_q);

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: reg_rdata <= {31'h0, rcfg_en_q};
                REG_INST_MASK: reg_rdata <= {11'h0, inst_mask_q};
                REG_RCFG_LO: reg_rdata <= {11'h0, rcfg_lo_q};
                REG_RCFG_HI: reg_rdata <= {11'h0, rcfg_hi_q};
                REG_STATUS: reg_rdata <= {26'h0, status_q};
                REG_IMASK: reg_rdata <= {26'h0, imask_q};
                REG_STATE: reg_rdata <= {26'h0, exec_cause_q, state_q};
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    AST_HW_EXCH: assert property (@(posedge ref_clk) disable iff (rst)
        (running && hw_err) |=> exec_exchange_q)
        else $error("no hw exchange");
    AST_HW_MON_LOCK: assert property (@(posedge ref_clk) disable iff (rst)
        (running && hw_err && monitor_mode) |=> (state_q == ST_LOCK) ##1 sim_halt_q)
        else $error("no monitor halt");
    AST_HW_JOB_RET: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_EXEC && exec_done && exec_cause_q == CAUSE_HW_JOB) |=> return_monitor_q)
        else $error("no return to monitor");
    AST_PP_REFUSE: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_LOCK) |-> !pp_exch_grant)
        else $error("grant while locked");
    AST_MON_SW: assert property (@(posedge ref_clk) disable iff (rst)
        (running && monitor_mode && !hw_err && inst_valid && illegal)
        |=> exec_exchange_q && exec_cause_q == CAUSE_SW_MON)
        else $error("no monitor exchange");
    AST_JOB_MICRO: assert property (@(posedge ref_clk) disable iff (rst)
        (running && !monitor_mode && !hw_err && inst_valid && illegal && inst_op != OP_TRAP)
        |=> micro_trap_q && !exec_exchange_q)
        else $error("no microcode trap");
    AST_TRAP_EXEC: assert property (@(posedge ref_clk) disable iff (rst)
        (running && !monitor_mode && !hw_err && inst_valid && inst_op == OP_TRAP)
        |=> exec_exchange_q && exec_cause_q == CAUSE_TRAP)
        else $error("no trap exchange");
    AST_NOMEM: assert property (@(posedge ref_clk) disable iff (rst)
        (mem_req && no_mem) |=> !mem_go_q && !mem_wr_q && (mem_read_ones_q == !$past(mem_wr)))
        else $error("nonexistent access");
    AST_RANGE_NOGO: assert property (@(posedge ref_clk) disable iff (rst)
        (mem_req && (range_err || undef_op)) |-> !commit_ok ##1 !mem_go_q)
        else $error("out of range access went ahead");
    AST_PRECISE: assert property (@(posedge ref_clk) disable iff (rst)
        (inst_valid && illegal) |-> !commit_ok)
        else $error("illegal commit");
    AST_UEM_ILL: assert property (@(posedge ref_clk) disable iff (rst)
        (!xpkg_flags[FLAG_UEM_BIT] && (inst_op == OP_XRD || inst_op == OP_BCOPY_WR)) |-> illegal)
        else $error("extended op legal");
    AST_PARCEL3: assert property (@(posedge ref_clk) disable iff (rst)
        (inst_long && inst_parcel == PARCEL_LAST) |-> illegal)
        else $error("long op in parcel 3");
    AST_BCOPY_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
        (inst_op == OP_BCOPY_RD && index_register_zero_b23 && extended_field_length_b23)
        |-> illegal)
        else $error("flag register block copy legal");
    AST_XRD_OK: assert property (@(posedge ref_clk) disable iff (rst)
        (inst_op == OP_XRD && xpkg_flags[FLAG_UEM_BIT] && inst_parcel == PARCEL_FIRST)
        |-> !illegal)
        else $error("extended read illegal");
endmodule

// file: test/ced_mem_model.sv
/* Central-memory stand-in for the error dispatch bench.
   Assumes the registered memory outputs of ced_top drive it. */
`timescale 1ns/100ps
module ced_mem_model (
    input wire logic ref_clk,
    input wire logic mem_go_q,
    input wire logic mem_wr_q,
    input wire logic mem_read_ones_q,
    input wire logic [ced_pkg::CM_ADDR_W-1:0] mem_abs_q,
    input wire logic [59:0] wdata,
    output logic [59:0] rdata
);
    logic [59:0] store_q [16];
    // dropped write
    // A refused write leaves the word untouched.
    always_ff @(posedge ref_clk) begin
        if (mem_go_q && mem_wr_q) begin
            store_q[mem_abs_q[3:0]] <= wdata;
        end
    end
    // ones on read
    // Idle cycles show the inverse, so stale data never pass.
    assign rdata = mem_read_ones_q ? {60{1'b1}} :
        (mem_go_q ? store_q[mem_abs_q[3:0]] : ~store_q[mem_abs_q[3:0]]);
endmodule

// file: test/cp_error_dispatch_addr_check_test.sv
/* Self-checking bench for ced_top and the memory model.
   Assumes ced_pkg constants and a 100 MHz ref_clk. */
`timescale 1ns/100ps
module cp_error_dispatch_addr_check_test;
    import ced_pkg::*;
    logic ref_clk, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, inst_valid = 1'b0, inst_long = 1'b0;
    logic monitor_mode = 1'b0, xb = 1'b0, fb = 1'b0, mem_req = 1'b0;
    logic mem_wr = 1'b0, pp_exch_req = 1'b0;
    logic [3:0] pul = 4'h0; // 0 hw_err 1 exec_done 2 deadstart 3 arith_fault
    logic irq, commit_ok, mem_go_q, mem_wr_q, mem_read_ones_q, pp_exch_grant, cok;
    logic exec_exchange_q, micro_trap_q, return_monitor_q, sim_halt_q;
    logic [3:0] reg_addr = 4'h0;
    logic [3:0] exec_cause_q;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [8:0] inst_op = 9'h000;
    logic [1:0] inst_parcel = 2'h0;
    logic [5:0] xpkg_flags = 6'h00;
    logic [23:0] rel = 24'h0;
    logic [20:0] fl = 21'h0, mem_abs_q;
    logic [59:0] wdata = 60'h0, rdata;
    int failures = 0, samples_checked = 0;
    ced_top i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .inst_valid(inst_valid), .inst_op(inst_op), .inst_parcel(inst_parcel),
        .inst_long(inst_long), .monitor_mode(monitor_mode), .index_register_zero_b23(xb),
        .extended_field_length_b23(fb), .xpkg_flags(xpkg_flags), .exit_mode_range(1'b1),
        .exit_mode_arith(1'b1), .arith_fault(pul[3]), .commit_ok(commit_ok),
        .mem_req(mem_req), .mem_wr(mem_wr), .mem_fetch(1'b0), .mem_rel_addr(rel),
        .ref_addr_central(21'h000100), .central_field_length(fl), .mem_go_q(mem_go_q),
        .mem_wr_q(mem_wr_q), .mem_read_ones_q(mem_read_ones_q), .mem_abs_q(mem_abs_q),
        .hw_err(pul[0]), .exec_done(pul[1]), .deadstart(pul[2]),
        .pp_exch_req(pp_exch_req), .pp_exch_grant(pp_exch_grant),
        .exec_exchange_q(exec_exchange_q), .exec_cause_q(exec_cause_q),
        .micro_trap_q(micro_trap_q), .return_monitor_q(return_monitor_q),
        .sim_halt_q(sim_halt_q));
    ced_mem_model i_mem (.ref_clk(ref_clk), .mem_go_q(mem_go_q), .mem_wr_q(mem_wr_q),
        .mem_read_ones_q(mem_read_ones_q), .mem_abs_q(mem_abs_q), .wdata(wdata), .rdata(rdata));
    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(n, e, reg_rdata);
    endtask
    // f: monitor, extended enable, index bit 23, field bit 23.
    task automatic issue(input logic [8:0] o, input logic [1:0] p, input logic l,
                         input logic [3:0] f);
        @(posedge ref_clk);
        inst_valid <= 1'b1;
        inst_op <= o;
        inst_parcel <= p;
        inst_long <= l;
        {monitor_mode, xpkg_flags[5], xb, fb} <= f;
        #1 cok = commit_ok;
        @(posedge ref_clk);
        inst_valid <= 1'b0;
        #1;
    endtask
    task automatic ev(input int i);
        @(posedge ref_clk);
        pul[i] <= 1'b1;
        @(posedge ref_clk);
        pul[i] <= 1'b0;
        #1;
    endtask
    task automatic dec(input logic [8:0] o, input logic [1:0] p, input logic l,
                       input logic [3:0] f, input logic ill);
        issue(o, p, l, f);
        chk("commit_ok", !ill, cok);
        chk("micro_trap_q", ill, micro_trap_q);
    endtask
    task automatic mem(input logic [23:0] r, input logic w, input logic [20:0] len);
        @(posedge ref_clk);
        mem_req <= 1'b1;
        mem_wr <= w;
        rel <= r;
        fl <= len;
        wdata <= {36'h0, r} ^ 60'hA5A5A5A5A5A5A5A;
        @(posedge ref_clk);
        mem_req <= 0;
        #1;
    endtask
    task automatic exch(input logic [3:0] c);
        chk("exec_exchange_q", 1, exec_exchange_q);
        chk("exec_cause_q", c, exec_cause_q);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs_irq;
        rd(REG_INST_MASK, 32'h001FFFFF, "inst_mask");
        rd(4'hF, 32'h0, "unmapped");
        wr(REG_STATUS, 32'h3F);
        rd(REG_STATUS, 32'h0, "status");
        dec(OP_XCHG, 2'h1, 0, 4'h4, 1);
        rd(REG_STATUS, 32'h2, "status");
        chk("irq", 0, irq);
        wr(REG_IMASK, 32'h2);
        chk("irq", 1, irq);
        wr(REG_STATUS, 32'h2);
        chk("irq", 0, irq);
        $display("test regs_irq done");
    endtask
    task automatic t_decode;
        dec(OP_XCHG, 2'h0, 0, 4'h4, 0);
        dec(OP_CMP_LO, 2'h2, 0, 4'h4, 1);
        dec(OP_CMP_HI, 2'h3, 0, 4'h4, 1);
        dec(9'h150, 2'h3, 1, 4'h4, 1);
        dec(9'h150, 2'h2, 1, 4'h4, 0);
        dec(OP_BCOPY_RD, 2'h1, 0, 4'h4, 1);
        dec(OP_XRD, 2'h0, 0, 4'h0, 1);
        dec(OP_XWR, 2'h0, 0, 4'h7, 0);
        dec(OP_BCOPY_RD, 2'h0, 0, 4'h7, 1);
        dec(OP_BCOPY_WR, 2'h0, 0, 4'h6, 0);
        dec(OP_BCOPY_WR, 2'h0, 0, 4'h0, 1);
        issue(OP_TRAP, 2'h0, 0, 4'h4);
        exch(CAUSE_TRAP);
        chk("micro_trap_q", 0, micro_trap_q);
        ev(1);
        $display("test decode done");
    endtask
    task automatic t_monitor;
        issue(OP_XCHG, 2'h1, 0, 4'hC);
        exch(CAUSE_SW_MON);
        issue(OP_XCHG, 2'h1, 0, 4'hC);
        chk("exec_exchange_q", 0, exec_exchange_q);
        ev(1);
        rd(REG_STATE, 32'hC, "state");
        issue(9'h000, 2'h0, 0, 4'hC);
        exch(CAUSE_SW_MON);
        ev(1);
        ev(3);
        exch(CAUSE_SW_MON);
        ev(1);
        ev(0);
        exch(CAUSE_HW_MON);
        rd(REG_STATE, 32'hA, "state");
        chk("sim_halt_q", 1, sim_halt_q);
        @(posedge ref_clk);
        pp_exch_req <= 1'b1;
        #1 chk("pp_exch_grant", 0, pp_exch_grant);
        ev(1);
        chk("sim_halt_q", 1, sim_halt_q);
        ev(2);
        chk("sim_halt_q", 0, sim_halt_q);
        chk("pp_exch_grant", 1, pp_exch_grant);
        pp_exch_req <= 1'b0;
        $display("test monitor done");
    endtask
    task automatic t_hw_job;
        issue(9'h150, 2'h0, 1, 4'h4);
        @(posedge ref_clk);
        pul[0] <= 1'b1;
        inst_valid <= 1'b1;
        inst_op <= OP_TRAP;
        @(posedge ref_clk);
        pul[0] <= 1'b0;
        inst_valid <= 1'b0;
        #1 exch(CAUSE_HW_JOB);
        ev(1);
        for (int i = 0; i < 4 && return_monitor_q !== 1'b1; i++) @(posedge ref_clk) #1;
        chk("return_monitor_q", 1, return_monitor_q);
        $display("test hw_job done");
    endtask
    task automatic t_memory;
        wr(REG_INST_MASK, 32'h00000FFF);
        mem(24'h000010, 1, 21'h001000);
        chk("mem_abs_q", 21'h000110, mem_abs_q);
        chk("mem_wr_q", 1, mem_wr_q);
        mem(24'h000010, 0, 21'h001000);
        chk("rdata", 60'hA5A5A5A5A5A5A4A, rdata);
        mem(24'h001000, 0, 21'h001000);
        chk("mem_go_q", 0, mem_go_q);
        mem(24'h200000, 0, 21'h1FFFFF);
        chk("mem_go_q", 0, mem_go_q);
        mem(24'h002000, 1, 21'h1FFFFF);
        chk("mem_wr_q", 0, mem_wr_q);
        mem(24'h002000, 0, 21'h1FFFFF);
        chk("rdata", {60{1'b1}}, rdata);
        mem(24'h000010, 0, 21'h001000);
        chk("rdata", 60'hA5A5A5A5A5A5A4A, rdata);
        wr(REG_RCFG_LO, 32'h3000);
        wr(REG_RCFG_HI, 32'h4000);
        wr(REG_CTRL, 32'h1);
        mem(24'h002F10, 0, 21'h1FFFFF);
        chk("mem_abs_q", 21'h000010, mem_abs_q);
        chk("mem_read_ones_q", 0, mem_read_ones_q);
        $display("test memory done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // About a hundred cycles are needed; this is ample.
    initial begin
        #100000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs_irq();
        t_decode();
        t_monitor();
        t_hw_job();
        t_memory();
        complete_run();
    end
endmodule
